// [rtl/mcg_pkg.sv]
// Purpose: Shared constants and helpers for the mirror command generator.
// Assumes: Fixed-point real spectra, coefficients in signed Q1.14.
// Notes:   Offsets, widths, codes and the state set live here only.

package mcg_pkg;

  // ************************************************************
  // Widths and default sizes
  // ************************************************************
  localparam int MCG_DW        = 16; // Data word width
  localparam int MCG_CW        = 16; // Coefficient word width
  localparam int MCG_FRAC      = 14; // Coefficient fraction bits
  localparam int MCG_GRID_LOG2 = 3;  // Grid is 2**n per axis
  localparam int MCG_FW_LOG2   = 2;  // Woofer cutoff box 2**n per axis
  localparam int MCG_NLAYERS   = 4;  // Atmospheric layers per element
  localparam int MCG_LUT_BITS  = 5;  // Quantizer bits per lookup axis
  localparam int MCG_CAW       = 12; // Coefficient load address width

  // ************************************************************
  // Coefficient load selects
  // ************************************************************
  localparam logic [2:0] MCG_SEL_FIT   = 3'h0; // Woofer fit filter
  localparam logic [2:0] MCG_SEL_INFL  = 3'h1; // Woofer influence filter
  localparam logic [2:0] MCG_SEL_BILAP = 3'h2; // Bi-Laplacian operator
  localparam logic [2:0] MCG_SEL_KERN  = 3'h3; // Inverse transform kernel
  localparam logic [2:0] MCG_SEL_LUT   = 3'h4; // Voltage lookup table

  // ************************************************************
  // Output word kinds
  // ************************************************************
  localparam logic [1:0] MCG_KIND_WCMD  = 2'h0; // Woofer command
  localparam logic [1:0] MCG_KIND_WSHP  = 2'h1; // Woofer shape feedback
  localparam logic [1:0] MCG_KIND_TVOLT = 2'h2; // Tweeter voltage

  // Output buffer depth, the fill count at which it is full
  localparam logic [1:0] MCG_BUF_FULL = 2'h2;

  // ************************************************************
  // Sequencer states
  // ************************************************************
  typedef enum logic [2:0] {
    MCG_S_LOAD  = 3'b000, // Accept and sum layers
    MCG_S_FIT   = 3'b001, // Mask and fit woofer commands
    MCG_S_SPLIT = 3'b010, // Replicate, shape, residual, force
    MCG_S_XFORM = 3'b011, // Inverse transform for one actuator
    MCG_S_LUT   = 3'b100, // Voltage table lookup
    MCG_S_EMIT  = 3'b101, // Hand voltage to output buffer
    MCG_S_DONE  = 3'b110  // Frame complete
  } mcg_state_t;

  // Signed Q1.14 coefficient times data word, scaled back
  function automatic logic signed [MCG_DW-1:0] mcg_mulq(
    input logic signed [MCG_CW-1:0] c,
    input logic signed [MCG_DW-1:0] d
  );
    logic signed [MCG_DW+MCG_CW-1:0] p;
    p = c * d;
    return p[MCG_FRAC+MCG_DW-1:MCG_FRAC];
  endfunction : mcg_mulq

endpackage : mcg_pkg

// [rtl/mcg_ram.sv]
// Purpose: Simple dual-port memory with registered read data.
// Assumes: One write port, one read port, same clock.
// Notes:   Read data holds while the read enable is low.

`timescale 1ns/100ps
`default_nettype none

module mcg_ram #(
  parameter int WIDTH = 16,
  parameter int ALOG2 = 6
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_we,
  input  wire logic [ALOG2-1:0] i_waddr,
  input  wire logic [WIDTH-1:0] i_wdata,
  input  wire logic             i_re,
  input  wire logic [ALOG2-1:0] i_raddr,
  output logic      [WIDTH-1:0] o_rdata
);

  // Storage array
  logic [WIDTH-1:0] mem_r [(1<<ALOG2)];

  // ************************************************************
  // Write and registered read
  // ************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_we) begin
      mem_r[i_waddr] <= i_wdata;
    end
    if (i_re) begin
      o_rdata <= mem_r[i_raddr];
    end
  end

endmodule : mcg_ram

`default_nettype wire

// [rtl/mcg_core.sv]
// Purpose: Frequency-domain woofer/tweeter command generator, one frame per step.
// Assumes: Volume stream ordered element by element, layers innermost.
// Notes:   Coefficients load through one port; results leave via a 2-entry buffer.
//
// Contract
// - Sum all layers per frequency element
// - Keep element only inside woofer cutoff box
// - Woofer commands: fit filter times low-order phase
// - Mirror-replicate commands band by band over grid
// - Woofer shape: commands times influence filter
// - Tweeter shape: ground phase minus woofer shape
// - Plate force: bi-Laplacian times tweeter shape
// - Inverse-transform shape and force before voltages
// - Per-actuator voltage from force, displacement lookup
// - Feed back actual woofer shape, not tweeter

`timescale 1ns/100ps
`default_nettype none

module mcg_core
  import mcg_pkg::*;
#(
  parameter int GRID_LOG2 = mcg_pkg::MCG_GRID_LOG2,
  parameter int FW_LOG2   = mcg_pkg::MCG_FW_LOG2,
  parameter int NLAYERS   = mcg_pkg::MCG_NLAYERS,
  parameter int LUT_BITS  = mcg_pkg::MCG_LUT_BITS
) (
  input  wire logic                               i_sys_clk,
  input  wire logic                               i_reset,
  input  wire logic                               i_vol_valid,
  output logic                                    o_vol_ready,
  input  wire logic signed [mcg_pkg::MCG_DW-1:0]  i_vol_data,
  input  wire logic                               i_coef_we,
  input  wire logic [2:0]                         i_coef_sel,
  input  wire logic [mcg_pkg::MCG_CAW-1:0]        i_coef_addr,
  input  wire logic signed [mcg_pkg::MCG_CW-1:0]  i_coef_data,
  output logic                                    o_out_valid,
  input  wire logic                               i_out_ready,
  output logic [1:0]                              o_out_kind,
  output logic [2*GRID_LOG2-1:0]                  o_out_index,
  output logic signed [mcg_pkg::MCG_DW-1:0]       o_out_data,
  output logic                                    o_frame_done,
  output logic                                    o_busy
);

  import mcg_pkg::*;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int IW = 2 * GRID_LOG2;                   // Element index width
  localparam int LW = (NLAYERS > 1) ? $clog2(NLAYERS) : 1; // Layer count width
  localparam int AW = MCG_DW + MCG_CW + IW;            // Transform accumulator
  localparam int BW = 2 + IW + MCG_DW;                 // Buffer word width
  localparam logic [IW-1:0] LAST_EL  = '1;             // Final element index
  localparam logic [LW-1:0] LAST_LAY = LW'(NLAYERS - 1);

  // ************************************************************
  // State and counters
  // ************************************************************
  mcg_state_t        state_r;     // Sequencer state
  logic [IW-1:0]     cnt_r;       // Element or transform term counter
  logic [IW-1:0]     act_r;       // Actuator being transformed
  logic [LW-1:0]     lay_r;       // Layer within current element
  logic signed [MCG_DW-1:0] sum_r; // Running layer sum
  logic              iss_done_r;  // All pass addresses issued
  logic              p_vld_r;     // Read data valid this cycle
  logic [IW-1:0]     p_idx_r;     // Element whose data is present
  logic              p_last_r;    // Present element is the last
  logic signed [AW-1:0] accd_r;   // Spatial displacement sum
  logic signed [AW-1:0] accf_r;   // Spatial force sum

  // Memory read data
  logic signed [MCG_DW-1:0] phi_q, aw_q, tw_q, frc_q, volt_q;
  logic signed [MCG_CW-1:0] fit_q, infl_q, blap_q, kern_q;

  // Datapath nets
  logic              pass;        // A pipelined pass is running
  logic              inbox;       // Present element inside cutoff box
  logic              need_push;   // Present element emits a word
  logic              stall;       // Output buffer refuses the word
  logic              adv;         // Pass pipeline advances
  logic              wr_el;       // Present element is written back
  logic [IW-1:0]     fold_addr;   // Replicated source for woofer command
  logic signed [MCG_DW-1:0] low_ph, aw_v, shp_v, tw_v, frc_v;
  logic signed [MCG_DW-1:0] spd, spf;   // Scaled spatial values
  logic [2*LUT_BITS-1:0]    lut_addr;   // Voltage table address
  logic              ld_take;     // Volume word accepted

  // Output buffer
  logic              buf_in_valid;
  logic              buf_in_ready;
  logic [BW-1:0]     buf_in;
  logic [BW-1:0]     e0_r, e1_r;  // Head and second entry
  logic [1:0]        fill_r;      // Entries held
  logic              push, pop;

  // Mirror one axis index into the in-box range
  function automatic logic [GRID_LOG2-1:0] fold_axis(input logic [GRID_LOG2-1:0] f);
    logic [FW_LOG2-1:0] r;
    r = f[FW_LOG2] ? ~f[FW_LOG2-1:0] : f[FW_LOG2-1:0]; // Upper band mirrors down
    return GRID_LOG2'(r);
  endfunction : fold_axis

  // ************************************************************
  // Combinational datapath
  // ************************************************************
  assign pass    = (state_r == MCG_S_FIT) || (state_r == MCG_S_SPLIT) ||
                   (state_r == MCG_S_XFORM);
  assign ld_take = i_vol_valid && o_vol_ready;

  // Inside box when no axis bit at or above the cutoff is set
  assign inbox = (p_idx_r[GRID_LOG2-1:FW_LOG2] == '0) &&
                 (p_idx_r[IW-1:GRID_LOG2+FW_LOG2] == '0);

  assign low_ph = inbox ? phi_q : '0;
  assign aw_v   = mcg_mulq(fit_q, low_ph);
  assign shp_v  = mcg_mulq(infl_q, aw_q);
  assign tw_v   = phi_q - shp_v;
  assign frc_v  = mcg_mulq(blap_q, tw_v);

  // Source element for replicated woofer commands
  assign fold_addr = {fold_axis(cnt_r[IW-1:GRID_LOG2]),
                      fold_axis(cnt_r[GRID_LOG2-1:0])};

  // Spatial values scaled back and quantized, offset binary
  assign spd = accd_r[MCG_FRAC+MCG_DW-1:MCG_FRAC];
  assign spf = accf_r[MCG_FRAC+MCG_DW-1:MCG_FRAC];
  assign lut_addr = {~spf[MCG_DW-1], spf[MCG_DW-2 -: LUT_BITS-1],
                     ~spd[MCG_DW-1], spd[MCG_DW-2 -: LUT_BITS-1]};

  // Pass pipeline control; the transform pass never stalls
  always_comb begin
    need_push = 1'b0;
    if (state_r == MCG_S_FIT) begin
      need_push = inbox;
    end else if (state_r == MCG_S_SPLIT) begin
      need_push = 1'b1;
    end
  end
  assign stall = p_vld_r && need_push && !buf_in_ready;
  assign adv   = pass && !stall;
  assign wr_el = adv && p_vld_r;

  // Word offered to the output buffer
  always_comb begin
    buf_in_valid = 1'b0;
    buf_in       = '0;
    if (state_r == MCG_S_FIT) begin
      buf_in_valid = p_vld_r && inbox;
      buf_in       = {MCG_KIND_WCMD, p_idx_r, aw_v};
    end else if (state_r == MCG_S_SPLIT) begin
      buf_in_valid = p_vld_r;
      buf_in       = {MCG_KIND_WSHP, p_idx_r, shp_v};
    end else if (state_r == MCG_S_EMIT) begin
      buf_in_valid = 1'b1;
      buf_in       = {MCG_KIND_TVOLT, act_r, volt_q};
    end
  end

  // ************************************************************
  // Memories
  // ************************************************************
  // Ground phase per element
  mcg_ram #(.WIDTH(MCG_DW), .ALOG2(IW)) u_phi (
    .i_sys_clk(i_sys_clk), .i_we(ld_take && lay_r == LAST_LAY),
    .i_waddr(cnt_r), .i_wdata(sum_r + i_vol_data),
    .i_re(adv), .i_raddr(cnt_r), .o_rdata(phi_q));
  // Woofer commands, in-box elements only
  mcg_ram #(.WIDTH(MCG_DW), .ALOG2(IW)) u_aw (
    .i_sys_clk(i_sys_clk), .i_we(wr_el && state_r == MCG_S_FIT && inbox),
    .i_waddr(p_idx_r), .i_wdata(aw_v),
    .i_re(adv), .i_raddr(fold_addr), .o_rdata(aw_q));
  // Tweeter shape and plate force spectra
  mcg_ram #(.WIDTH(2*MCG_DW), .ALOG2(IW)) u_twf (
    .i_sys_clk(i_sys_clk), .i_we(wr_el && state_r == MCG_S_SPLIT),
    .i_waddr(p_idx_r), .i_wdata({tw_v, frc_v}),
    .i_re(adv), .i_raddr(cnt_r), .o_rdata({tw_q, frc_q}));
  // Loadable fit filter
  mcg_ram #(.WIDTH(MCG_CW), .ALOG2(IW)) u_fit (
    .i_sys_clk(i_sys_clk), .i_we(i_coef_we && i_coef_sel == MCG_SEL_FIT),
    .i_waddr(i_coef_addr[IW-1:0]), .i_wdata(i_coef_data),
    .i_re(adv), .i_raddr(cnt_r), .o_rdata(fit_q));
  // Influence filter
  mcg_ram #(.WIDTH(MCG_CW), .ALOG2(IW)) u_infl (
    .i_sys_clk(i_sys_clk), .i_we(i_coef_we && i_coef_sel == MCG_SEL_INFL),
    .i_waddr(i_coef_addr[IW-1:0]), .i_wdata(i_coef_data),
    .i_re(adv), .i_raddr(cnt_r), .o_rdata(infl_q));
  // Bi-Laplacian operator
  mcg_ram #(.WIDTH(MCG_CW), .ALOG2(IW)) u_blap (
    .i_sys_clk(i_sys_clk), .i_we(i_coef_we && i_coef_sel == MCG_SEL_BILAP),
    .i_waddr(i_coef_addr[IW-1:0]), .i_wdata(i_coef_data),
    .i_re(adv), .i_raddr(cnt_r), .o_rdata(blap_q));
  // Inverse transform kernel, row per actuator
  mcg_ram #(.WIDTH(MCG_CW), .ALOG2(2*IW)) u_kern (
    .i_sys_clk(i_sys_clk), .i_we(i_coef_we && i_coef_sel == MCG_SEL_KERN),
    .i_waddr(i_coef_addr[2*IW-1:0]), .i_wdata(i_coef_data),
    .i_re(adv), .i_raddr({act_r, cnt_r}), .o_rdata(kern_q));
  // Voltage table indexed by force and displacement
  mcg_ram #(.WIDTH(MCG_DW), .ALOG2(2*LUT_BITS)) u_lut (
    .i_sys_clk(i_sys_clk), .i_we(i_coef_we && i_coef_sel == MCG_SEL_LUT),
    .i_waddr(i_coef_addr[2*LUT_BITS-1:0]), .i_wdata(i_coef_data),
    .i_re(state_r == MCG_S_LUT), .i_raddr(lut_addr), .o_rdata(volt_q));

  // ************************************************************
  // Layer summing input stage
  // ************************************************************
  // Accumulates layers; the last layer's sum goes straight to memory
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      lay_r <= '0;
      sum_r <= '0;
    end else if (ld_take) begin
      if (lay_r == LAST_LAY) begin
        lay_r <= '0;
        sum_r <= '0;
      end else begin
        lay_r <= lay_r + LW'(1);
        sum_r <= sum_r + i_vol_data;
      end
    end
  end

  // ************************************************************
  // Sequencer and pass pipeline
  // ************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_r    <= MCG_S_LOAD;
      cnt_r      <= '0;
      act_r      <= '0;
      iss_done_r <= 1'b0;
      p_vld_r    <= 1'b0;
      p_idx_r    <= '0;
      p_last_r   <= 1'b0;
    end else begin
      unique case (state_r)
        // Element index steps once per summed element
        MCG_S_LOAD: begin
          if (ld_take && lay_r == LAST_LAY) begin
            cnt_r <= cnt_r + IW'(1);
            if (cnt_r == LAST_EL) begin
              state_r <= MCG_S_FIT;
            end
          end
        end
        // Three pipelined passes share one address walker
        MCG_S_FIT, MCG_S_SPLIT, MCG_S_XFORM: begin
          if (adv) begin
            p_vld_r  <= !iss_done_r;
            p_idx_r  <= cnt_r;
            p_last_r <= (cnt_r == LAST_EL);
            if (!iss_done_r) begin
              cnt_r      <= cnt_r + IW'(1);
              iss_done_r <= (cnt_r == LAST_EL);
            end
            if (p_vld_r && p_last_r) begin
              iss_done_r <= 1'b0;
              p_vld_r    <= 1'b0;
              if (state_r == MCG_S_FIT) begin
                state_r <= MCG_S_SPLIT;
              end else if (state_r == MCG_S_SPLIT) begin
                state_r <= MCG_S_XFORM;
              end else begin
                state_r <= MCG_S_LUT;
              end
            end
          end
        end
        // Table read issued this cycle
        MCG_S_LUT: begin
          state_r <= MCG_S_EMIT;
        end
        // Wait for buffer room, then next actuator
        MCG_S_EMIT: begin
          if (buf_in_ready) begin
            if (act_r == LAST_EL) begin
              act_r   <= '0;
              state_r <= MCG_S_DONE;
            end else begin
              act_r   <= act_r + IW'(1);
              state_r <= MCG_S_XFORM;
            end
          end
        end
        // Frame complete; accept next frame
        MCG_S_DONE: begin
          state_r <= MCG_S_LOAD;
        end
        default: begin
          state_r <= MCG_S_LOAD;
        end
      endcase
    end
  end

  // ************************************************************
  // Inverse transform accumulators
  // ************************************************************
  // First term of each actuator restarts the sums
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      accd_r <= '0;
      accf_r <= '0;
    end else if (state_r == MCG_S_XFORM && wr_el) begin
      accd_r <= ((p_idx_r == '0) ? AW'(0) : accd_r) + AW'(kern_q) * AW'(tw_q);
      accf_r <= ((p_idx_r == '0) ? AW'(0) : accf_r) + AW'(kern_q) * AW'(frc_q);
    end
  end

  // ************************************************************
  // Frame status
  // ************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_frame_done <= 1'b0;
    end else begin
      o_frame_done <= (state_r == MCG_S_DONE);
    end
  end

  assign o_vol_ready = (state_r == MCG_S_LOAD);
  assign o_busy      = (state_r != MCG_S_LOAD);

  // ************************************************************
  // Two-entry output buffer
  // ************************************************************
  assign buf_in_ready = (fill_r != MCG_BUF_FULL);
  assign push         = buf_in_valid && buf_in_ready;
  assign pop          = o_out_valid && i_out_ready;

  // Head entry holds its word until the driver takes it
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      fill_r <= '0;
      e0_r   <= '0;
      e1_r   <= '0;
    end else begin
      unique case ({push, pop})
        2'b10: begin
          if (fill_r == 2'h0) begin
            e0_r <= buf_in;
          end else begin
            e1_r <= buf_in;
          end
          fill_r <= fill_r + 2'h1;
        end
        2'b01: begin
          e0_r   <= e1_r;
          fill_r <= fill_r - 2'h1;
        end
        2'b11: begin
          if (fill_r == 2'h1) begin
            e0_r <= buf_in;
          end else begin
            e0_r <= e1_r;
            e1_r <= buf_in;
          end
        end
        2'b00: begin
          fill_r <= fill_r;
        end
      endcase
    end
  end

  assign o_out_valid = (fill_r != 2'h0);
  assign o_out_kind  = e0_r[BW-1 -: 2];
  assign o_out_index = e0_r[MCG_DW +: IW];
  assign o_out_data  = e0_r[MCG_DW-1:0];

endmodule : mcg_core

`default_nettype wire

// [bench/mcg_core_asserts.sv]
// Purpose: Port-level checks for the command generator core.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Inbox test assumes the default box of half the grid per axis.
`timescale 1ns/100ps
`default_nettype none
module mcg_core_asserts
  import mcg_pkg::*;
#(
  parameter int GRID_LOG2 = 3,
  parameter int NLAYERS   = 4
) (
  input wire logic                              i_sys_clk,
  input wire logic                              i_reset,
  input wire logic                              i_vol_valid,
  input wire logic                              o_vol_ready,
  input wire logic                              o_out_valid,
  input wire logic                              i_out_ready,
  input wire logic [1:0]                        o_out_kind,
  input wire logic [2*GRID_LOG2-1:0]            o_out_index,
  input wire logic signed [mcg_pkg::MCG_DW-1:0] o_out_data,
  input wire logic                              o_frame_done,
  input wire logic                              o_busy
);
  localparam int LAST = (NLAYERS << (2*GRID_LOG2)) - 1; // Final input word
  logic [15:0] vol_cnt_r;                               // Words taken
  wire  logic  take = i_vol_valid && o_vol_ready;       // Input handshake
  wire  logic  pop  = o_out_valid && i_out_ready;       // Output handshake
  // Count input words; cleared whenever loading is over
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || !o_vol_ready) begin
      vol_cnt_r <= 16'h0000;
    end else if (i_vol_valid) begin
      vol_cnt_r <= vol_cnt_r + 16'h0001;
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  chk_ready_idle: assert property (o_vol_ready != o_busy)
    else $error("input ready not inverse of busy");
  chk_reset_idle: assert property ($fell(i_reset)
    |-> o_vol_ready && !o_out_valid && !o_busy)
    else $error("outputs not idle after reset");
  chk_load_hold: assert property (o_vol_ready && !(take && vol_cnt_r == LAST)
    |=> o_vol_ready)
    else $error("input ready dropped mid frame");
  chk_load_end: assert property (take && vol_cnt_r == LAST |=> !o_vol_ready)
    else $error("input ready stayed after last word");
  chk_out_hold: assert property (o_out_valid && !i_out_ready |=> o_out_valid
    && $stable(o_out_kind) && $stable(o_out_index) && $stable(o_out_data))
    else $error("stalled output word changed");
  chk_done_pulse: assert property (o_frame_done |=> !o_frame_done)
    else $error("frame done longer than one cycle");
  chk_cmd_inbox: assert property (o_out_valid && o_out_kind == MCG_KIND_WCMD
    |-> !o_out_index[2*GRID_LOG2-1] && !o_out_index[GRID_LOG2-1])
    else $error("woofer command outside cutoff box");
  chk_kind_code: assert property (o_out_valid |-> o_out_kind != 2'h3)
    else $error("unknown output kind");
  chk_shape_after: assert property (pop && o_out_kind == MCG_KIND_WSHP
    |=> !(o_out_valid && o_out_kind == MCG_KIND_WCMD))
    else $error("command after shape words");
  chk_volt_after: assert property (pop && o_out_kind == MCG_KIND_TVOLT
    |=> !(o_out_valid && o_out_kind != MCG_KIND_TVOLT))
    else $error("spectral word after voltages");
endmodule : mcg_core_asserts
bind mcg_core mcg_core_asserts #(.GRID_LOG2(GRID_LOG2), .NLAYERS(NLAYERS)) u_chk (
  .i_sys_clk, .i_reset, .i_vol_valid, .o_vol_ready, .o_out_valid, .i_out_ready,
  .o_out_kind, .o_out_index, .o_out_data, .o_frame_done, .o_busy);
`default_nettype wire

// [bench/mcg_drv_model.sv]
// Purpose: Mirror driver model taking the output word stream.
// Assumes: Words are taken on valid and ready high at a rising edge.
// Notes:   Stall mode opens ready one cycle in four.
`timescale 1ns/100ps
`default_nettype none
module mcg_drv_model
  import mcg_pkg::*;
(
  input  wire logic                              i_sys_clk,
  input  wire logic                              i_reset,
  input  wire logic                              i_stall,
  input  wire logic                              i_valid,
  input  wire logic [1:0]                        i_kind,
  input  wire logic [5:0]                        i_index,
  input  wire logic signed [mcg_pkg::MCG_DW-1:0] i_data,
  output logic                                   o_ready
);
  logic [1:0]  ph_r;     // Stall phase
  logic [23:0] cap_q[$]; // Taken words {kind,index,data}
  // Advance phase and record each word taken
  always @(posedge i_sys_clk) begin
    ph_r <= i_reset ? 2'h0 : ph_r + 2'h1;
    if (!i_reset && i_valid && o_ready) begin
      cap_q.push_back({i_kind, i_index, i_data});
    end
  end
  assign o_ready = !i_stall || (ph_r == 2'h3);
endmodule : mcg_drv_model
`default_nettype wire

// [bench/mirror_command_generator_bench.sv]
// Purpose: Self-checking bench for the command generator core.
// Assumes: Identity kernel, unit influence, half-scale plate operator.
// Notes:   Table entry value equals its own address.
`timescale 1ns/100ps
`default_nettype none
module mirror_command_generator_bench;
  import mcg_pkg::*;
  logic i_sys_clk, i_reset, i_vol_valid, o_vol_ready, i_coef_we, stall;
  logic o_out_valid, i_out_ready, o_frame_done, o_busy;
  logic [2:0]               i_coef_sel;
  logic [MCG_CAW-1:0]       i_coef_addr;
  logic signed [MCG_DW-1:0] i_vol_data, i_coef_data, o_out_data;
  logic [1:0]               o_out_kind;
  logic [5:0]               o_out_index;
  int                       err_count, checks_done;
  mcg_core DUT (.i_sys_clk, .i_reset, .i_vol_valid, .o_vol_ready, .i_vol_data,
    .i_coef_we, .i_coef_sel, .i_coef_addr, .i_coef_data, .o_out_valid, .i_out_ready,
    .o_out_kind, .o_out_index, .o_out_data, .o_frame_done, .o_busy);
  mcg_drv_model drv (.i_sys_clk, .i_reset, .i_stall(stall), .i_valid(o_out_valid),
    .i_kind(o_out_kind), .i_index(o_out_index), .i_data(o_out_data), .o_ready(i_out_ready));
  // Clock
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  // Compare and count
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // One coefficient word
  task automatic wc(input logic [2:0] sel, input int a, input logic [15:0] d);
    @(negedge i_sys_clk);
    i_coef_we = 1'b1;
    i_coef_sel = sel;
    i_coef_addr = 12'(a);
    i_coef_data = d;
  endtask : wc
  // One frame with fit gain, optional stall and refused extra words
  task automatic t_frame(input logic [15:0] fitv, input logic stl, input logic junk);
    logic signed [15:0] phi[64], aw[64], sh, tw, fc;
    logic signed [31:0] p;
    logic [5:0]         x, s;
    int                 n, dn, k;
    dn = 0;
    k = 0;
    for (int e = 0; e < 64; e++) wc(MCG_SEL_FIT, e, fitv);
    @(negedge i_sys_clk) i_coef_we = 1'b0;
    stall = stl;
    for (int e = 0; e < 64; e++) begin
      phi[e] = 16'h0000;
      for (int l = 0; l < 4; l++) begin
        @(negedge i_sys_clk);
        check(24'(o_vol_ready), 24'h1);
        i_vol_valid = 1'b1;
        i_vol_data = 16'(e * 1531 + l * 2749 - 20000);
        phi[e] = phi[e] + i_vol_data;
      end
    end
    repeat (junk ? 8 : 1) begin
      @(negedge i_sys_clk);
      check(24'(o_vol_ready), 24'h0);
      i_vol_data = 16'h7FFF;
      i_vol_valid = junk;
    end
    if (junk) @(negedge i_sys_clk) i_vol_valid = 1'b0;
    for (n = 0; n < 40000 && !(drv.cap_q.size() == 144 && o_vol_ready === 1'b1); n++) begin
      @(negedge i_sys_clk);
      if (o_frame_done === 1'b1) dn++;
    end
    if (n == 40000) begin
      err_count++;
      final_report();
    end
    repeat (3) @(negedge i_sys_clk) if (o_frame_done === 1'b1) dn++;
    check(24'(dn), 24'h1);
    for (int e = 0; e < 64; e++) begin
      p = phi[e] * $signed(fitv);
      aw[e] = p[29:14];
      x = 6'(e);
      if (!x[5] && !x[2]) check(drv.cap_q[k++], {2'h0, x, aw[e]});
    end
    for (int e = 0; e < 64; e++) begin
      x = 6'(e);
      s = {1'b0, x[4:3] ^ {2{x[5]}}, 1'b0, x[1:0] ^ {2{x[2]}}};
      sh = aw[s];
      check(drv.cap_q[16 + e], {2'h1, x, sh});
      tw = phi[e] - sh;
      p = tw * 16'sh2000;
      fc = p[29:14];
      check(drv.cap_q[80 + e], {2'h2, x, 6'h00, ~fc[15], fc[14:11],
        ~tw[15], tw[14:11]});
    end
    drv.cap_q.delete();
    stall = 1'b0;
    $display("frame test done, fit %h stall %0b", fitv, stl);
  endtask : t_frame
  // Main sequence
  initial begin
    i_reset = 1'b1;
    i_vol_valid = 1'b0;
    i_vol_data = 16'h0000;
    i_coef_we = 1'b0;
    i_coef_sel = 3'h0;
    i_coef_addr = 12'h000;
    i_coef_data = 16'h0000;
    stall = 1'b0;
    err_count = 0;
    checks_done = 0;
    repeat (5) @(negedge i_sys_clk);
    i_reset = 1'b0;
    check({o_vol_ready, o_out_valid, o_busy, o_frame_done}, 24'h8);
    $display("reset test done");
    for (int a = 0; a < 64; a++) wc(MCG_SEL_INFL, a, 16'h4000);
    for (int a = 0; a < 64; a++) wc(MCG_SEL_BILAP, a, 16'h2000);
    for (int a = 0; a < 4096; a++) wc(MCG_SEL_KERN, a, (a[11:6] == a[5:0]) ? 16'h4000 : 16'h0000);
    for (int a = 0; a < 1024; a++) wc(MCG_SEL_LUT, a, 16'(a));
    t_frame(16'h4000, 1'b0, 1'b0);
    t_frame(16'h2000, 1'b1, 1'b1);
    t_frame(16'h4000, 1'b0, 1'b0);
    final_report();
  end
endmodule : mirror_command_generator_bench
`default_nettype wire
